// ---- hdl/bmp_top.sv ----
// bmp_top: parallel master/slave port with queues and AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module bmp_top
	import bmp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// port data bus
	input wire logic [DATA_W-1:0] port_data_bus_in,
	output logic [DATA_W-1:0] port_data_bus_out,
	output logic port_data_bus_oe,
	// port clock or select
	input wire logic port_clock_or_select_in,
	output logic port_clock_or_select_out,
	output logic port_clock_or_select_oe,
	// port write indicator
	input wire logic port_write_indicator_in,
	output logic port_write_indicator_out,
	output logic port_write_indicator_oe,
	// port wait, active low
	input wire logic port_wait_n_in,
	output logic port_wait_n_out,
	output logic port_wait_n_oe,
	// port outputs
	output logic port_read_strobe_n,
	output logic port_read_request,
	output logic port_receive_full,
	// interrupt
	output logic irq
);

	typedef struct packed {
		logic [31:0] ctrl;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		bmp_mst_e mst;
		logic [DIV_W-1:0] div_cnt;
		logic m_write;
		logic clk_out;
		logic strobe_n;
		logic clk_prev;
		logic wm_prev;
		logic [DATA_W-1:0] data_out;
		logic data_oe;
		logic wait_n;
		logic wait_oe;
	} bmp_top_s;

	bmp_top_s st;
	bmp_top_s next_st;

	logic [SYNC_W-1:0] syn_q;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic [DATA_W-1:0] tx_push_data;
	logic [DATA_W-1:0] rx_push_data;
	logic tx_ready;
	logic tx_valid;
	logic rx_ready;
	logic rx_valid;
	logic [DATA_W-1:0] tx_data;
	logic [DATA_W-1:0] rx_data;
	logic [LVL_W-1:0] tx_level;
	logic [LVL_W-1:0] rx_level;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] irq_clr;
	logic wr_go;
	logic tick;
	logic en;
	logic wide;
	logic mread;
	logic master_on;
	logic slave_on;
	logic clk_s;
	logic wr_s;
	logic wait_s;
	logic [DATA_W-1:0] data_s;
	logic [LVL_W-1:0] wm;
	logic [DIV_W-1:0] div;
	logic rx_full_lvl;

	// pins from outside pass two flip-flops
	bmp_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({port_wait_n_in, port_write_indicator_in,
			port_clock_or_select_in, port_data_bus_in}),
		.q(syn_q)
	);

	// transmit queue: software fills, port drains
	bmp_queue u_transmit_queue (
		.aclk(aclk),
		.aresetn(aresetn),
		.push_valid(tx_push),
		.push_data(tx_push_data),
		.push_ready(tx_ready),
		.pop_valid(tx_valid),
		.pop_data(tx_data),
		.pop_ready(tx_pop),
		.level(tx_level)
	);

	// receive queue: port fills, software drains
	bmp_queue u_receive_queue (
		.aclk(aclk),
		.aresetn(aresetn),
		.push_valid(rx_push),
		.push_data(rx_push_data),
		.push_ready(rx_ready),
		.pop_valid(rx_valid),
		.pop_data(rx_data),
		.pop_ready(rx_pop),
		.level(rx_level)
	);

	// control fields and synchronised pins
	assign en = st.ctrl[CTRL_EN];
	assign wide = st.ctrl[CTRL_WIDE];
	assign mread = st.ctrl[CTRL_MREAD];
	assign master_on = en && st.ctrl[CTRL_MASTER];
	assign slave_on = en && !st.ctrl[CTRL_MASTER];
	assign wm = st.ctrl[CTRL_WM_LSB +: LVL_W];
	assign div = st.ctrl[CTRL_DIV_LSB +: DIV_W];
	assign clk_s = syn_q[SYN_CLK];
	assign wr_s = syn_q[SYN_WR];
	assign wait_s = syn_q[SYN_WAIT];
	assign data_s = syn_q[DATA_W-1:0];
	assign rx_full_lvl = (rx_level >= wm);

	// next state of bus slave, master sequencer and slave port
	always_comb begin
		next_st = st;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_push_data = '0;
		ev = '0;
		irq_clr = '0;
		tx_push_data = bmp_width_mask(st.w_data[DATA_W-1:0], wide);
		wr_go = st.aw_held && st.w_held && !st.bvalid;
		tick = (st.div_cnt == '0);

		// write address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case (st.aw_addr)
				OFS_CTRL: begin
					next_st.ctrl = bmp_apply_strb(st.ctrl, st.w_data, st.w_strb);
				end
				OFS_TXDATA: begin
					tx_push = st.w_strb[0];
					ev[IRQ_ERR] = st.w_strb[0] && !tx_ready; // push into full
				end
				OFS_IRQ_STAT: begin
					irq_clr = st.w_strb[0] ? st.w_data[IRQ_W-1:0] : '0;
				end
				OFS_IRQ_MASK: begin
					if (st.w_strb[0]) begin
						next_st.irq_mask = st.w_data[IRQ_W-1:0];
					end
				end
				OFS_STATUS, OFS_RXDATA: begin
					next_st.bresp = RESP_OKAY; // read only, write ignored
				end
				default: begin
					next_st.bresp = RESP_SLVERR;
				end
			endcase
		end

		// read channel answers one cycle after the address is taken
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = '0;
			case (s_axi_araddr)
				OFS_CTRL: begin
					next_st.rdata = st.ctrl;
				end
				OFS_STATUS: begin
					next_st.rdata[STAT_TX_LSB +: LVL_W] = tx_level;
					next_st.rdata[STAT_RX_LSB +: LVL_W] = rx_level;
					next_st.rdata[STAT_BUSY] = (st.mst != MST_IDLE);
				end
				OFS_TXDATA: begin
					next_st.rdata = '0;
				end
				OFS_RXDATA: begin
					// an empty queue reads as zero, not as a stale entry
					next_st.rdata[DATA_W-1:0] = rx_valid ? rx_data : '0;
					rx_pop = 1'b1;
					ev[IRQ_ERR] = ev[IRQ_ERR] || !rx_valid; // read from empty
				end
				OFS_IRQ_STAT: begin
					next_st.rdata[IRQ_W-1:0] = st.irq_stat;
				end
				OFS_IRQ_MASK: begin
					next_st.rdata[IRQ_W-1:0] = st.irq_mask;
				end
				default: begin
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end

		// divider gives the master clock its half periods
		next_st.div_cnt = tick ? div : (st.div_cnt - DIV_W'(1));

		// master sequencer: setup with clock low, then clock high
		case (st.mst)
			MST_IDLE: begin
				next_st.clk_out = 1'b0;
				next_st.strobe_n = 1'b1;
				if (master_on && !mread && tx_valid) begin
					next_st.m_write = 1'b1;
					next_st.data_out = bmp_width_mask(tx_data, wide);
					next_st.data_oe = 1'b1;
					next_st.div_cnt = div;
					next_st.mst = MST_SETUP;
				end else if (master_on && mread && rx_ready) begin
					next_st.m_write = 1'b0;
					next_st.strobe_n = 1'b0;
					next_st.data_oe = 1'b0;
					next_st.div_cnt = div;
					next_st.mst = MST_SETUP;
				end
			end
			MST_SETUP: begin
				if (tick) begin
					next_st.clk_out = 1'b1;
					next_st.mst = MST_STROBE;
				end
			end
			MST_STROBE: begin
				if (tick && wait_s) begin
					next_st.clk_out = 1'b0;
					next_st.strobe_n = 1'b1;
					next_st.data_oe = 1'b0;
					next_st.mst = MST_IDLE;
					ev[IRQ_DONE] = 1'b1;
					if (st.m_write) begin
						tx_pop = 1'b1;
					end else begin
						rx_push = 1'b1;
						rx_push_data = bmp_width_mask(data_s, wide);
					end
				end
			end
			default: begin
				next_st.mst = MST_IDLE;
			end
		endcase
		if (!master_on && st.mst != MST_IDLE) begin
			next_st.mst = MST_IDLE; // leaving master mode aborts the cycle
			next_st.clk_out = 1'b0;
			next_st.strobe_n = 1'b1;
		end

		// slave port: external master clocks every access
		next_st.clk_prev = clk_s;
		if (slave_on) begin
			next_st.data_out = bmp_width_mask(tx_data, wide);
			next_st.data_oe = !wr_s;
			next_st.wait_oe = 1'b1;
			next_st.wait_n = wr_s ? rx_ready : tx_valid;
			if (clk_s && !st.clk_prev) begin
				if (wr_s && rx_ready) begin
					rx_push = 1'b1;
					rx_push_data = bmp_width_mask(data_s, wide);
					ev[IRQ_DONE] = 1'b1;
				end else if (!wr_s && tx_valid) begin
					tx_pop = 1'b1;
					ev[IRQ_DONE] = 1'b1;
				end
			end
		end else begin
			next_st.wait_oe = 1'b0;
			next_st.wait_n = 1'b1;
			if (!master_on) begin
				next_st.data_oe = 1'b0;
			end
		end

		// sticky status, an event in the clearing cycle wins
		next_st.wm_prev = rx_full_lvl;
		ev[IRQ_WM] = rx_full_lvl && !st.wm_prev;
		next_st.irq_stat = (st.irq_stat & ~irq_clr) | ev;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.mst <= MST_IDLE;
			st.strobe_n <= 1'b1;
			st.wait_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// bus handshakes
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready = !st.w_held && !st.bvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	// port pins
	assign port_data_bus_out = st.data_out;
	assign port_data_bus_oe = st.data_oe;
	assign port_clock_or_select_out = st.clk_out;
	assign port_clock_or_select_oe = master_on;
	assign port_write_indicator_out = st.m_write;
	assign port_write_indicator_oe = master_on;
	assign port_wait_n_out = st.wait_n;
	assign port_wait_n_oe = st.wait_oe;
	assign port_read_strobe_n = st.strobe_n;
	assign port_read_request = slave_on && (tx_level != '0);
	assign port_receive_full = rx_full_lvl;
	assign irq = |(st.irq_stat & st.irq_mask);

	// checks on the port behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	narrow_data_a: assert property (slave_on && $past(slave_on) && !wide
		&& $past(!wide) && port_data_bus_oe
		|-> port_data_bus_out[DATA_W-1:BYTE_W] == '0)
		else $error("upper byte driven in narrow mode");
	slave_dir_a: assert property (slave_on |-> !port_write_indicator_oe
		&& !port_clock_or_select_oe)
		else $error("slave drives write indicator or clock");
	master_dir_a: assert property (master_on |-> port_write_indicator_oe
		&& port_clock_or_select_oe)
		else $error("master does not drive write indicator");
	read_level_a: assert property (!port_read_strobe_n
		|-> !port_write_indicator_out && st.mst != MST_IDLE)
		else $error("read strobe low with write indicator high");
	strobe_slave_a: assert property (!master_on && $past(!master_on)
		|-> port_read_strobe_n)
		else $error("read strobe low outside master mode");
	read_req_a: assert property ($rose(port_read_request)
		|-> slave_on && tx_level >= LVL_W'(1))
		else $error("read request without a transmit entry");
	rx_full_a: assert property (rx_level >= wm |-> port_receive_full)
		else $error("receive full low at watermark");
	wait_hold_a: assert property (st.mst == MST_STROBE && tick && !wait_s
		&& master_on |=> st.mst == MST_STROBE && port_clock_or_select_out)
		else $error("master completed while wait low");
	master_end_a: assert property (st.mst == MST_STROBE && tick && wait_s
		&& master_on |=> st.mst == MST_IDLE && !port_clock_or_select_out
		&& st.irq_stat[IRQ_DONE])
		else $error("master cycle did not complete");
	irq_level_a: assert property (|(st.irq_stat & st.irq_mask) |-> irq)
		else $error("interrupt low with unmasked status");

	// main scenarios
	master_write_c: cover property (st.mst == MST_STROBE && st.m_write
		&& tick && wait_s);
	master_read_c: cover property (st.mst == MST_STROBE && !st.m_write
		&& tick && wait_s);
	slave_write_c: cover property (slave_on && rx_push);
	slave_read_c: cover property (slave_on && tx_pop);

endmodule

// ---- hdl/bmp_pkg.sv ----
// bmp_pkg: constants, register map, types and helpers of the parallel port
package bmp_pkg;

	// widths and depths
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int QDEPTH = 8;
	localparam int QPTR_W = 3;
	localparam int LVL_W = 4;
	localparam int ADDR_W = 8;
	localparam int DIV_W = 8;
	localparam int SYNC_W = 19;

	// bit positions in the synchronised pin word
	localparam int SYN_CLK = 16;
	localparam int SYN_WR = 17;
	localparam int SYN_WAIT = 18;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

	// control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_MASTER = 1;
	localparam int CTRL_WIDE = 2;
	localparam int CTRL_MREAD = 3;
	localparam int CTRL_WM_LSB = 8;
	localparam int CTRL_DIV_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0001_0400;

	// status register fields
	localparam int STAT_TX_LSB = 0;
	localparam int STAT_RX_LSB = 8;
	localparam int STAT_BUSY = 16;

	// interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_WM = 1;
	localparam int IRQ_ERR = 2;

	// bus responses and masks
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [DATA_W-1:0] LOW_BYTE_MASK = 16'h00ff;

	// master sequencer states
	typedef enum logic [1:0] {MST_IDLE, MST_SETUP, MST_STROBE} bmp_mst_e;

	// merge a write word into a register under byte strobes
	function automatic logic [31:0] bmp_apply_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
			end
		end
		return res;
	endfunction

	// clear the upper byte when the port runs eight bits wide
	function automatic logic [DATA_W-1:0] bmp_width_mask(
		input logic [DATA_W-1:0] data, input logic wide);
		return wide ? data : (data & LOW_BYTE_MASK);
	endfunction

endpackage

// ---- hdl/bmp_sync.sv ----
// bmp_sync: two flip-flop synchroniser for the port input pins
`timescale 1ns/1ps
module bmp_sync
	import bmp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// asynchronous pins and their synchronised copy
	input wire logic [SYNC_W-1:0] d,
	output logic [SYNC_W-1:0] q
);

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} bmp_sync_s;

	bmp_sync_s st;
	bmp_sync_s next_st;

	// first stage only feeds the second
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.s2;

endmodule

// ---- hdl/bmp_queue.sv ----
// bmp_queue: flip-flop queue with valid/ready on both sides
`timescale 1ns/1ps
module bmp_queue
	import bmp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// filling side
	input wire logic push_valid,
	input wire logic [DATA_W-1:0] push_data,
	output logic push_ready,
	// draining side
	output logic pop_valid,
	output logic [DATA_W-1:0] pop_data,
	input wire logic pop_ready,
	// fill level
	output logic [LVL_W-1:0] level
);

	typedef struct packed {
		logic [QDEPTH-1:0][DATA_W-1:0] mem;
		logic [QPTR_W-1:0] wr;
		logic [QPTR_W-1:0] rd;
		logic [LVL_W-1:0] cnt;
	} bmp_queue_s;

	bmp_queue_s st;
	bmp_queue_s next_st;
	logic do_push;
	logic do_pop;

	// pointer and level update
	always_comb begin
		next_st = st;
		do_push = push_valid && push_ready;
		do_pop = pop_valid && pop_ready;
		if (do_push) begin
			next_st.mem[st.wr] = push_data;
			next_st.wr = st.wr + QPTR_W'(1);
		end
		if (do_pop) begin
			next_st.rd = st.rd + QPTR_W'(1);
		end
		if (do_push && !do_pop) begin
			next_st.cnt = st.cnt + LVL_W'(1);
		end else if (do_pop && !do_push) begin
			next_st.cnt = st.cnt - LVL_W'(1);
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// honest full and empty
	assign push_ready = (st.cnt != LVL_W'(QDEPTH));
	assign pop_valid = (st.cnt != '0);
	assign pop_data = st.mem[st.rd];
	assign level = st.cnt;

endmodule

// ---- verif/bmp_far_end.sv ----
// bmp_far_end: external master or slave facing the parallel port pins
`timescale 1ns/1ps
module bmp_far_end
	import bmp_pkg::*;
(
	// clock
	input wire logic aclk,
	// resolved pin levels and device state
	input wire logic dev_master,
	input wire logic dev_cyc,
	input wire logic clk_line,
	input wire logic wr_line,
	input wire logic wait_line,
	input wire logic strobe_n,
	input wire logic [DATA_W-1:0] data_line,
	// far side drive
	output logic f_clk,
	output logic f_wr,
	output logic f_wait_n,
	output logic [DATA_W-1:0] f_data,
	output logic f_data_oe
);
	int stall = 0;
	int cnt = 0;
	int lowrun = 0;
	int viol = 0;
	logic clk_q = 1'b0;
	logic cyc_q = 1'b0;
	logic m_oe = 1'b0;
	logic [DATA_W-1:0] m_data = 16'h0000;
	logic [DATA_W-1:0] rd_word = 16'h0000;
	logic [DATA_W-1:0] last_wr = 16'h0000;

	// slave role answers reads only while the strobe is low
	assign f_wait_n = (cnt == 0);
	assign f_data_oe = m_oe | (dev_master & !strobe_n);
	assign f_data = m_oe ? m_data : rd_word;

	// idle link: clock still, write indicator high so nobody collides
	initial begin
		f_clk <= 1'b0;
		f_wr <= 1'b1;
	end

	// slave role: stretch each cycle, record writes, flag bad completions
	always @(posedge aclk) begin
		clk_q <= clk_line;
		cyc_q <= dev_cyc;
		if (dev_master && dev_cyc && !cyc_q) begin
			cnt <= stall;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
		lowrun <= f_wait_n ? 0 : lowrun + 1;
		if (dev_master && clk_line && !clk_q) begin
			if (strobe_n) begin
				last_wr <= data_line;
			end
			if (wr_line !== strobe_n) begin
				viol <= viol + 1;
			end
		end
		if (dev_master && !clk_line && clk_q && lowrun > 0) begin
			viol <= viol + 1;
		end
	end

	// master role: one write cycle of at least 200 ns, held off while wait is low
	task automatic ext_write(input logic [DATA_W-1:0] d);
		f_wr <= 1'b1;
		m_data <= d;
		m_oe <= 1'b1;
		repeat (10) @(posedge aclk);
		while (!wait_line) @(posedge aclk);
		f_clk <= 1'b1;
		repeat (10) @(posedge aclk);
		f_clk <= 1'b0;
		repeat (5) @(posedge aclk);
		m_oe <= 1'b0;
	endtask

	// master role: one read cycle, data taken at the rising clock
	task automatic ext_read(output logic [DATA_W-1:0] d);
		f_wr <= 1'b0;
		repeat (10) @(posedge aclk);
		while (!wait_line) @(posedge aclk);
		f_clk <= 1'b1;
		d = data_line;
		repeat (10) @(posedge aclk);
		f_clk <= 1'b0;
		repeat (5) @(posedge aclk);
		f_wr <= 1'b1;
	endtask
endmodule

// ---- verif/bmp_top_tb.sv ----
// bmp_top_tb: register and pin checks of the parallel port
`timescale 1ns/1ps
module bmp_top_tb
	import bmp_pkg::*;
;
	logic aclk, aresetn, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, r;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [DATA_W-1:0] port_data_bus_in, port_data_bus_out, f_data, fd;
	logic [DATA_W-1:0] flt = 16'h5a5a;
	logic port_data_bus_oe, port_read_strobe_n, port_read_request;
	logic port_receive_full, f_doe, far_clk, far_wr, far_wait;
	logic port_clock_or_select_in, port_clock_or_select_out;
	logic port_clock_or_select_oe, port_wait_n_in, port_wait_n_out;
	logic port_write_indicator_in, port_write_indicator_out;
	logic port_write_indicator_oe, port_wait_n_oe;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;

	// wire levels from every party's enable; a free bus keeps changing
	assign port_clock_or_select_in = port_clock_or_select_oe ?
		port_clock_or_select_out : far_clk;
	assign port_write_indicator_in = port_write_indicator_oe ?
		port_write_indicator_out : far_wr;
	assign port_wait_n_in = port_wait_n_oe ? port_wait_n_out : far_wait;
	assign port_data_bus_in = port_data_bus_oe ? port_data_bus_out :
		(f_doe ? f_data : flt);

	bmp_top dut (.*);

	bmp_far_end far (.aclk(aclk), .dev_master(port_clock_or_select_oe),
		.dev_cyc(port_data_bus_oe | !port_read_strobe_n),
		.clk_line(port_clock_or_select_in), .wr_line(port_write_indicator_in),
		.wait_line(port_wait_n_in), .strobe_n(port_read_strobe_n),
		.data_line(port_data_bus_in), .f_clk(far_clk), .f_wr(far_wr),
		.f_wait_n(far_wait), .f_data(f_data), .f_data_oe(f_doe));

	// clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// floating bus pattern and hang guard
	always @(posedge aclk) begin
		flt <= ~flt;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// axi4-lite write: address and data together, then the response
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		logic aw;
		logic w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// axi4-lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// read a register until the masked value matches, bounded
	task automatic poll(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] rs;
		int k;
		k = 0;
		do begin
			axi_rd(a, d, rs);
			k++;
		end while ((d & m) !== e && k < 300);
		chk(d & m, e);
	endtask

	// main sequence
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// reset state and an unmapped offset
		axi_rd(OFS_CTRL, r, resp);
		chk(r, CTRL_RESET);
		chk({port_read_strobe_n, port_read_request, port_receive_full}, 3'b100);
		axi_rd(8'h18, r, resp);
		chk(resp, RESP_SLVERR);
		// slave writes, eight bits wide, watermark two, its interrupt on
		axi_wr(OFS_IRQ_MASK, 32'h0000_0002, resp);
		axi_wr(OFS_CTRL, 32'h0001_0201, resp);
		far.ext_write(16'h1234);
		@(posedge aclk);
		chk({port_receive_full, irq}, 2'b00);
		far.ext_write(16'h00c5);
		@(posedge aclk);
		chk({port_receive_full, irq, port_read_strobe_n}, 3'b111);
		axi_wr(OFS_IRQ_STAT, 32'h0000_0002, resp);
		chk(irq, 1'b0);
		axi_rd(OFS_RXDATA, r, resp);
		chk(r, 32'h0000_0034);
		axi_rd(OFS_RXDATA, r, resp);
		chk(r, 32'h0000_00c5);
		// empty read gives zero and flags an error; unmapped write refused
		axi_rd(OFS_RXDATA, r, resp);
		chk(r, 32'h0000_0000);
		axi_rd(OFS_IRQ_STAT, r, resp);
		chk(r & 32'h0000_0004, 32'h0000_0004);
		axi_wr(8'h18, 32'h0000_0000, resp);
		chk(resp, RESP_SLVERR);
		// slave read, sixteen bits wide
		axi_wr(OFS_CTRL, 32'h0001_0205, resp);
		axi_wr(OFS_TXDATA, 32'h0000_abcd, resp);
		chk(port_read_request, 1'b1);
		far.ext_read(fd);
		chk(fd, 16'habcd);
		repeat (8) @(posedge aclk);
		chk(port_read_request, 1'b0);
		// master write stretched by a slow slave
		far.stall <= 12;
		axi_wr(OFS_TXDATA, 32'h0000_5a5a, resp);
		axi_wr(OFS_CTRL, 32'h0001_0207, resp);
		chk({port_clock_or_select_oe, port_write_indicator_oe}, 2'b11);
		poll(OFS_STATUS, 32'h0001_000f, 32'h0000_0000);
		chk(far.last_wr, 16'h5a5a);
		// master reads until the receive queue is full
		far.rd_word <= 16'h1357;
		axi_wr(OFS_CTRL, 32'h0001_020f, resp);
		poll(OFS_STATUS, 32'h0001_0f00, 32'h0000_0800);
		chk(far.viol, 0);
		axi_wr(OFS_CTRL, 32'h0001_0200, resp);
		axi_rd(OFS_RXDATA, r, resp);
		chk(r, 32'h0000_1357);
		chk(port_read_strobe_n, 1'b1);
		give_verdict();
	end
endmodule
